/* File: core/hwc_ctrl_regs.sv */
// Hardware control and watchdog control registers with their side effects.
// Assumes lock, failure, mode-change and watchdog inputs come from logic on clk_sys;
// only the serial pins are asynchronous and are synchronised in the frame engine.
//
// Notes on behaviour
// - Soft-reset bit 0 pulses reset output low.
// - Failure output from failures or software bit.
// - Software clear never releases a failure-held output.
// - Restart clears software failure-output activation bit.
// - Charge pump bit drives charge pump enable.
// - Tolerance bit: escalate on first or second failure.
// - Locks protect reset-select and charge pump bits from soft reset.
// - Hardware register reset, restart values, zero reserved.
// - Watchdog register reset, restart values, zero bit.
// - Stop-mode watchdog off bit a.
// - Watchdog type: timeout or window.
// - Watchdog starts after CAN wake when set.
// - Period field writable by software and hardware.
// - Mode field reset code executes soft reset.
// - Stop-to-normal change clears off bit b.
`timescale 1ns/1ps
module hwc_ctrl_regs #(
   parameter int RST_PULSE_CYC = hwc_pkg::RST_PULSE_CYCLES
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Serial pins
   input wire logic spi_clk_pin,
   input wire logic spi_sel_n_pin,
   input wire logic spi_din_pin,
   output logic spi_dout,
   output logic spi_dout_oe_n,
   // Device state inputs
   input wire logic cfg_lock_0,
   input wire logic cfg_lock_1,
   input wire logic restart_enter,
   input wire logic stop_to_normal,
   input wire logic failure_triggered,
   input wire logic fo_pin_configured,
   input wire logic wdog_trigger_fail,
   input wire logic wdog_period_hw_we,
   input wire logic [hwc_pkg::WD_PERIOD_MSB:0] wdog_period_hw_val,
   // Reset and failure outputs
   output logic reset_out_n,
   output logic soft_reset_evt,
   output logic failure_output,
   output logic charge_pump_enable,
   // Watchdog configuration outputs
   output logic wdog_escalate,
   output logic wdog_stop_disable,
   output logic window_type_select,
   output logic wdog_start_on_can_wake,
   output logic [hwc_pkg::WD_PERIOD_MSB:0] wdog_period_field,
   output logic wd_parity_reject
);
   import hwc_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (RST_PULSE_CYC < 1 || RST_PULSE_CYC >= (1 << RST_CNT_W)) begin : g_bad_pulse
      $error("RST_PULSE_CYC must lie between 1 and the counter range");
   end

   // ------------------------------------------------------------
   // Frame engine
   // ------------------------------------------------------------
   hwc_frame_if frm ();

   hwc_spi_frame u_frame (
      .clk_sys(clk_sys),
      .reset(reset),
      .spi_clk_pin(spi_clk_pin),
      .spi_sel_n_pin(spi_sel_n_pin),
      .spi_din_pin(spi_din_pin),
      .spi_dout(spi_dout),
      .spi_dout_oe_n(spi_dout_oe_n),
      .frm(frm)
   );

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   logic [DATA_W-1:0] hw_reg;
   logic [DATA_W-1:0] wd_reg;
   logic [DATA_W-1:0] wake_reg;
   logic wr_hw;
   logic wr_wd;
   logic wr_wake;
   logic wd_parity_ok;
   logic soft_rst_req;
   logic [DATA_W-1:0] lock_keep;

   assign wr_hw = frm.wr && (frm.addr == HW_CTRL_ADDR);
   assign wr_wd = frm.wr && (frm.addr == WATCHDOG_CONTROL_ADDR);
   assign wr_wake = frm.wr && (frm.addr == WAKE_CTRL_ADDR);
   // The checksum bit is part of the sum, so all eight bits must XOR to zero.
   assign wd_parity_ok = ~(^frm.wdata);
   assign soft_rst_req = frm.wr && (frm.addr == MODE_SUPPLY_ADDR)
      && (frm.wdata[MODE_MSB:MODE_LSB] == MODE_SOFT_RESET);

   always_comb begin
      lock_keep = '0;
      lock_keep[HW_SOFT_RST_BIT] = cfg_lock_1;
      lock_keep[HW_CHARGE_PUMP_ENABLE_BIT] = cfg_lock_0;
   end

   // ------------------------------------------------------------
   // Hardware control register
   // ------------------------------------------------------------
   // Soft reset beats restart, which beats a software write in the same cycle.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hw_reg <= HW_CTRL_RST;
      end else if (soft_rst_req) begin
         hw_reg <= (HW_CTRL_RST & ~lock_keep) | (hw_reg & lock_keep);
      end else if (restart_enter) begin
         hw_reg <= hw_reg & HW_RESTART_KEEP;
      end else if (wr_hw) begin
         hw_reg <= frm.wdata & HW_WR_MASK;
      end
   end

   assign charge_pump_enable = hw_reg[HW_CHARGE_PUMP_ENABLE_BIT];

   // ------------------------------------------------------------
   // Watchdog control register
   // ------------------------------------------------------------
   // A software write takes precedence over a hardware period update in the same cycle.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wd_reg <= WATCHDOG_CONTROL_RST;
      end else if (soft_rst_req) begin
         wd_reg <= WATCHDOG_CONTROL_RST;
      end else if (restart_enter) begin
         wd_reg <= (wd_reg & WD_RESTART_KEEP) | WD_RESTART_SET;
      end else if (wr_wd && wd_parity_ok) begin
         wd_reg <= frm.wdata & WD_WR_MASK;
      end else if (wdog_period_hw_we) begin
         wd_reg[WD_PERIOD_MSB:WD_PERIOD_LSB] <= wdog_period_hw_val;
      end
   end

   // Rejection is reported as a one-cycle pulse; the stored settings stay as they were.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wd_parity_reject <= 1'b0;
      end else begin
         wd_parity_reject <= wr_wd && !wd_parity_ok && !soft_rst_req
            && !restart_enter;
      end
   end

   assign window_type_select = wd_reg[WINDOW_TYPE_SELECT_BIT];
   assign wdog_start_on_can_wake = wd_reg[WD_CAN_WAKE_BIT];
   assign wdog_period_field = wd_reg[WD_PERIOD_MSB:WD_PERIOD_LSB];

   // ------------------------------------------------------------
   // Wake control register, second stop-mode deactivation bit
   // ------------------------------------------------------------
   // Only the deactivation bit lives here; the other bits of this address belong elsewhere
   // and read as zero from this block.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wake_reg <= WAKE_CTRL_RST;
      end else if (soft_rst_req) begin
         wake_reg <= WAKE_CTRL_RST;
      end else if (restart_enter) begin
         wake_reg <= wake_reg & WAKE_RESTART_KEEP;
      end else if (wr_wake) begin
         wake_reg <= frm.wdata & WAKE_WR_MASK;
      end else if (stop_to_normal) begin
         wake_reg[WAKE_STOP_OFF_B_BIT] <= 1'b0;
      end
   end

   // The watchdog is off in stop mode only when both deactivation bits are set.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wdog_stop_disable <= 1'b0;
      end else begin
         wdog_stop_disable <= wd_reg[WD_STOP_OFF_A_BIT]
            & wake_reg[WAKE_STOP_OFF_B_BIT];
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Reserved bits are never stored, so every read shows them as zero.
   always_comb begin
      case (frm.addr)
         HW_CTRL_ADDR: frm.rdata = hw_reg;
         WATCHDOG_CONTROL_ADDR: frm.rdata = wd_reg;
         WAKE_CTRL_ADDR: frm.rdata = wake_reg;
         default: frm.rdata = READ_UNMAPPED;
      endcase
   end

   // ------------------------------------------------------------
   // Soft reset and reset output pulse
   // ------------------------------------------------------------
   logic [RST_CNT_W-1:0] rst_cnt;

   // The selection is read before the soft reset rewrites it, so the old value decides.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rst_cnt <= '0;
         reset_out_n <= 1'b1;
      end else if (soft_rst_req && !hw_reg[HW_SOFT_RST_BIT]) begin
         rst_cnt <= RST_PULSE_CYC[RST_CNT_W-1:0];
         reset_out_n <= 1'b0;
      end else if (rst_cnt > 8'h01) begin
         rst_cnt <= rst_cnt - 8'h01;
      end else if (rst_cnt == 8'h01) begin
         rst_cnt <= '0;
         reset_out_n <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         soft_reset_evt <= 1'b0;
      end else begin
         soft_reset_evt <= soft_rst_req;
      end
   end

   // ------------------------------------------------------------
   // Failure output
   // ------------------------------------------------------------
   // A failure holds the output regardless of the software bit; clearing the bit
   // alone cannot release it, only the failure status going away can.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         failure_output <= 1'b0;
      end else begin
         failure_output <= (hw_reg[HW_FO_SW_BIT] & fo_pin_configured)
            | failure_triggered;
      end
   end

   // ------------------------------------------------------------
   // Watchdog failure tolerance
   // ------------------------------------------------------------
   logic fail_seen;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fail_seen <= 1'b0;
         wdog_escalate <= 1'b0;
      end else if (soft_rst_req || restart_enter) begin
         fail_seen <= 1'b0;
         wdog_escalate <= 1'b0;
      end else if (wdog_trigger_fail) begin
         if (hw_reg[HW_TOL_BIT] || fail_seen) begin
            fail_seen <= 1'b0;
            wdog_escalate <= 1'b1;
         end else begin
            fail_seen <= 1'b1;
            wdog_escalate <= 1'b0;
         end
      end else begin
         wdog_escalate <= 1'b0;
      end
   end

endmodule : hwc_ctrl_regs

/* File: core/hwc_frame_if.sv */
// Carries one decoded serial frame from the frame engine to the register file.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface hwc_frame_if;
   logic wr;
   logic [hwc_pkg::ADDR_W-1:0] addr;
   logic [hwc_pkg::DATA_W-1:0] wdata;
   logic [hwc_pkg::DATA_W-1:0] rdata;

   modport engine (output wr, output addr, output wdata, input rdata);
   modport regs (input wr, input addr, input wdata, output rdata);
endinterface : hwc_frame_if

/* File: core/hwc_pkg.sv */
// Constants shared by the hardware and watchdog control register block.
// Assumes a 20 MHz system clock and an 8-bit register file behind a 16-bit serial frame.
package hwc_pkg;

   // ------------------------------------------------------------
   // Serial frame layout
   // ------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int FRAME_BITS = 16;
   localparam int BIT_CNT_W = 5;
   localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
   localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
   localparam logic [4:0] CNT_ADDR_LAST = 5'h07;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [6:0] MODE_SUPPLY_ADDR = 7'h01;
   localparam logic [6:0] HW_CTRL_ADDR = 7'h02;
   localparam logic [6:0] WATCHDOG_CONTROL_ADDR = 7'h03;
   localparam logic [6:0] WAKE_CTRL_ADDR = 7'h06;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int HW_SOFT_RST_BIT = 6;
   localparam int HW_FO_SW_BIT = 5;
   localparam int HW_CHARGE_PUMP_ENABLE_BIT = 2;
   localparam int HW_TOL_BIT = 0;
   localparam int WD_CHECKSUM_BIT = 7;
   localparam int WD_STOP_OFF_A_BIT = 6;
   localparam int WINDOW_TYPE_SELECT_BIT = 5;
   localparam int WD_CAN_WAKE_BIT = 4;
   localparam int WD_PERIOD_MSB = 2;
   localparam int WD_PERIOD_LSB = 0;
   localparam int WAKE_STOP_OFF_B_BIT = 2;
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 6;
   localparam logic [1:0] MODE_SOFT_RESET = 2'h3;

   // ------------------------------------------------------------
   // Reset values and bit masks
   // ------------------------------------------------------------
   localparam logic [7:0] HW_CTRL_RST = 8'h00;
   localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h14;
   localparam logic [7:0] WAKE_CTRL_RST = 8'h00;
   localparam logic [7:0] HW_WR_MASK = 8'h65;
   localparam logic [7:0] WD_WR_MASK = 8'hF7;
   localparam logic [7:0] WAKE_WR_MASK = 8'h04;
   localparam logic [7:0] HW_RESTART_KEEP = 8'h45;
   localparam logic [7:0] WD_RESTART_KEEP = 8'hB0;
   localparam logic [7:0] WD_RESTART_SET = 8'h04;
   localparam logic [7:0] WAKE_RESTART_KEEP = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [2:0] WD_PERIOD_W3_ZERO = 3'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int RST_PULSE_NS = 2000;
   localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W = 8;

endpackage : hwc_pkg

/* File: core/hwc_spi_frame.sv */
// Serial frame engine: samples the pins, assembles 16-bit frames, shifts read data out.
// Assumes clock idle low, data taken on rising and changed on falling edges, each
// clock phase at least four clk_sys periods long.
`timescale 1ns/1ps
module hwc_spi_frame (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Pins
   input wire logic spi_clk_pin,
   input wire logic spi_sel_n_pin,
   input wire logic spi_din_pin,
   output logic spi_dout,
   output logic spi_dout_oe_n,
   // Register side
   hwc_frame_if.engine frm
);
   import hwc_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] clk_sync;
   logic [1:0] sel_sync;
   logic [1:0] din_sync;
   logic clk_prev;
   logic sel_prev;
   logic clk_s;
   logic sel_s;
   logic rise;
   logic fall;
   logic frame_end;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         clk_sync <= 2'h0;
         sel_sync <= 2'h3;
         din_sync <= 2'h0;
         clk_prev <= 1'b0;
         sel_prev <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[0], spi_clk_pin};
         sel_sync <= {sel_sync[0], spi_sel_n_pin};
         din_sync <= {din_sync[0], spi_din_pin};
         clk_prev <= clk_s;
         sel_prev <= sel_s;
      end
   end

   assign clk_s = clk_sync[1];
   assign sel_s = ~sel_sync[1];
   assign rise = clk_s & ~clk_prev;
   assign fall = ~clk_s & clk_prev;
   assign frame_end = sel_prev & ~sel_s;

   // ------------------------------------------------------------
   // Receive side
   // ------------------------------------------------------------
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic [FRAME_BITS-1:0] rx_shift;
   logic wr_flag;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bit_cnt <= '0;
         rx_shift <= '0;
         wr_flag <= 1'b0;
         frm.addr <= '0;
      end else if (!sel_s) begin
         bit_cnt <= '0;
      end else if (rise) begin
         rx_shift <= {rx_shift[FRAME_BITS-2:0], din_sync[1]};
         // Saturate past a full frame so an overlong frame is never taken.
         if (bit_cnt <= CNT_FRAME_DONE) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
         if (bit_cnt == CNT_ADDR_LAST) begin
            frm.addr <= {rx_shift[ADDR_W-2:0], din_sync[1]};
            wr_flag <= rx_shift[ADDR_W-1];
         end
      end
   end

   // A write takes effect only at deselect, and only for exactly sixteen bits.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         frm.wr <= 1'b0;
         frm.wdata <= '0;
      end else begin
         frm.wr <= frame_end && (bit_cnt == CNT_FRAME_DONE) && wr_flag;
         if (frame_end) begin
            frm.wdata <= rx_shift[DATA_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Transmit side
   // ------------------------------------------------------------
   logic [DATA_W-1:0] tx_shift;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tx_shift <= '0;
         spi_dout <= 1'b0;
         spi_dout_oe_n <= 1'b1;
      end else begin
         spi_dout_oe_n <= ~sel_s;
         if (!sel_s) begin
            tx_shift <= '0;
            spi_dout <= 1'b0;
         end else if (fall) begin
            if (bit_cnt == CNT_ADDR_DONE) begin
               spi_dout <= frm.rdata[DATA_W-1];
               tx_shift <= {frm.rdata[DATA_W-2:0], 1'b0};
            end else begin
               spi_dout <= tx_shift[DATA_W-1];
               tx_shift <= {tx_shift[DATA_W-2:0], 1'b0};
            end
         end
      end
   end

endmodule : hwc_spi_frame

/* File: dv/hwc_ctrl_regs_asserts.sv */
// Port-level checker for the hardware and watchdog control register block.
// Assumes one clock domain and the pulse and latency choices of the design.
`timescale 1ns/1ps
module hwc_ctrl_regs_asserts #(
   parameter int RST_PULSE_CYC = 40
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Watched inputs
   input wire logic spi_sel_n_pin,
   input wire logic restart_enter,
   input wire logic stop_to_normal,
   input wire logic failure_triggered,
   input wire logic fo_pin_configured,
   input wire logic wdog_trigger_fail,
   input wire logic wdog_period_hw_we,
   input wire logic [hwc_pkg::WD_PERIOD_MSB:0] wdog_period_hw_val,
   // Watched outputs
   input wire logic reset_out_n,
   input wire logic soft_reset_evt,
   input wire logic failure_output,
   input wire logic charge_pump_enable,
   input wire logic wdog_escalate,
   input wire logic wdog_stop_disable,
   input wire logic [hwc_pkg::WD_PERIOD_MSB:0] wdog_period_field,
   input wire logic wd_parity_reject
);
   import hwc_pkg::*;

   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   int unsigned low_cnt_reg;
   logic [WD_PERIOD_MSB:0] hv_reg;

   // Counts reset pulse length, too long for a repetition.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) low_cnt_reg <= 0;
      else if (!reset_out_n) low_cnt_reg <= low_cnt_reg + 1;
      else low_cnt_reg <= 0;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) hv_reg <= '0;
      else if (wdog_period_hw_we) hv_reg <= wdog_period_hw_val;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_rst_pulse_len: assert property ($rose(reset_out_n) |-> low_cnt_reg == RST_PULSE_CYC)
      else $error("bad reset pulse length");
   a_soft_evt_tie: assert property ($fell(reset_out_n) |-> soft_reset_evt)
      else $error("reset low without soft reset");
   a_fo_fail_hold: assert property (failure_triggered |=> failure_output)
      else $error("failure output not held");
   a_fo_unconf_off: assert property (!fo_pin_configured && !failure_triggered
      |=> !failure_output)
      else $error("failure output without cause");
   a_restart_fo_off: assert property (restart_enter ##1 !failure_triggered
      |=> !failure_output)
      else $error("failure output on after restart");
   a_esc_has_cause: assert property (wdog_escalate |-> $past(wdog_trigger_fail))
      else $error("escalation without failure");
   a_reject_one_cycle: assert property (wd_parity_reject |-> $past(spi_sel_n_pin, 2)
      ##1 !wd_parity_reject)
      else $error("bad reject pulse");
   a_cp_frame_only: assert property ($changed(charge_pump_enable)
      |-> $past(spi_sel_n_pin, 2))
      else $error("charge pump changed in frame");
   a_period_hw_load: assert property ((wdog_period_hw_we && !restart_enter && spi_sel_n_pin
      && $past(spi_sel_n_pin, 4)) ##1 (!restart_enter && !wdog_period_hw_we)
      |-> ##[0:1] wdog_period_field == hv_reg)
      else $error("period update lost");
   a_stop_off_clear: assert property (stop_to_normal && spi_sel_n_pin
      && $past(spi_sel_n_pin, 4) |-> ##[1:2] !wdog_stop_disable)
      else $error("stop disable not cleared");

endmodule : hwc_ctrl_regs_asserts

/* File: dv/hwc_ctrl_regs_tb_top.sv */
// Self-checking testbench for the hardware and watchdog control register block.
// Assumes the serial frame of the design; each serial clock high phase is five cycles, each low phase six.
`timescale 1ns/1ps
module hwc_ctrl_regs_tb_top;
   import hwc_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int RP = 4;
   logic clk_sys = 1'b0, reset = 1'b1;
   logic spi_clk_pin = 1'b0, spi_sel_n_pin = 1'b1, spi_din_pin = 1'b0;
   logic cfg_lock_0 = 1'b0, cfg_lock_1 = 1'b0, restart_enter = 1'b0, stop_to_normal = 1'b0;
   logic failure_triggered = 1'b0, fo_pin_configured = 1'b1, wdog_trigger_fail = 1'b0;
   logic wdog_period_hw_we = 1'b0;
   logic [2:0] wdog_period_hw_val = 3'h0;
   logic spi_dout, spi_dout_oe_n, reset_out_n, soft_reset_evt, failure_output;
   logic charge_pump_enable, wdog_escalate, wdog_stop_disable, window_type_select;
   logic wdog_start_on_can_wake, wd_parity_reject;
   logic [2:0] wdog_period_field;
   int bad_count = 0, checks_done = 0, esc_n = 0, rej_n = 0, low_n = 0, mark;
   logic [7:0] q;

   hwc_ctrl_regs #(.RST_PULSE_CYC(RP)) dut_u (.clk_sys, .reset, .spi_clk_pin, .spi_sel_n_pin,
      .spi_din_pin, .spi_dout, .spi_dout_oe_n, .cfg_lock_0, .cfg_lock_1, .restart_enter,
      .stop_to_normal, .failure_triggered, .fo_pin_configured, .wdog_trigger_fail,
      .wdog_period_hw_we, .wdog_period_hw_val, .reset_out_n, .soft_reset_evt, .failure_output,
      .charge_pump_enable, .wdog_escalate, .wdog_stop_disable, .window_type_select,
      .wdog_start_on_can_wake, .wdog_period_field, .wd_parity_reject);

   always #25 clk_sys = ~clk_sys;

   // Pulses are counted here so no scenario must catch one cycle.
   always @(posedge clk_sys) begin
      if (wdog_escalate === 1'b1) esc_n++;
      if (wd_parity_reject === 1'b1) rej_n++;
      if (reset_out_n === 1'b0) low_n++;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task spi(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] r);
      logic [15:0] f;
      f = {w, a, d};
      r = 8'h00;
      @(posedge clk_sys) spi_sel_n_pin <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk_sys) spi_din_pin <= f[i];
         tick(4);
         if (i < 8) r[i] = spi_dout;
         if (i == 0) chk({7'h00, spi_dout_oe_n}, 8'h00);
         @(posedge clk_sys) spi_clk_pin <= 1'b1;
         tick(4);
         @(posedge clk_sys) spi_clk_pin <= 1'b0;
      end
      tick(4);
      @(posedge clk_sys) spi_sel_n_pin <= 1'b1;
      tick(8);
   endtask : spi

   task wr(input logic [6:0] a, input logic [7:0] d);
      spi(1'b1, a, d, q);
   endtask : wr

   task rd(input logic [6:0] a, input logic [7:0] exp);
      spi(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask : rd

   task fail_pulse;
      @(posedge clk_sys) wdog_trigger_fail <= 1'b1;
      @(posedge clk_sys) wdog_trigger_fail <= 1'b0;
      tick(3);
   endtask : fail_pulse

   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset_values;
      chk({7'h00, spi_dout_oe_n}, 8'h01);
      rd(HW_CTRL_ADDR, 8'h00);
      rd(WATCHDOG_CONTROL_ADDR, 8'h14);
      chk({5'h00, wdog_period_field}, 8'h04);
      chk({7'h00, wdog_start_on_can_wake}, 8'h01);
      rd(7'h10, 8'h00);
      $display("reset done");
   endtask : t_reset_values

   task t_hw_bits;
      wr(HW_CTRL_ADDR, 8'hFF);
      rd(HW_CTRL_ADDR, 8'h65);
      chk({7'h00, charge_pump_enable}, 8'h01);
      chk({7'h00, failure_output}, 8'h01);
      @(posedge clk_sys) fo_pin_configured <= 1'b0;
      tick(3);
      chk({7'h00, failure_output}, 8'h00);
      @(posedge clk_sys) fo_pin_configured <= 1'b1;
      failure_triggered <= 1'b1;
      wr(HW_CTRL_ADDR, 8'h00);
      chk({7'h00, failure_output}, 8'h01);
      chk({7'h00, charge_pump_enable}, 8'h00);
      @(posedge clk_sys) failure_triggered <= 1'b0;
      tick(3);
      chk({7'h00, failure_output}, 8'h00);
      $display("hw bits done");
   endtask : t_hw_bits

   task t_wdog_bits;
      wr(WATCHDOG_CONTROL_ADDR, 8'h77);
      rd(WATCHDOG_CONTROL_ADDR, 8'h77);
      chk({5'h00, window_type_select, wdog_start_on_can_wake, 1'b0}, 8'h06);
      chk({5'h00, wdog_period_field}, 8'h07);
      mark = rej_n;
      wr(WATCHDOG_CONTROL_ADDR, 8'h26);
      rd(WATCHDOG_CONTROL_ADDR, 8'h77);
      chk(8'(rej_n - mark), 8'h01);
      wr(WATCHDOG_CONTROL_ADDR, 8'h5C);
      rd(WATCHDOG_CONTROL_ADDR, 8'h54);
      chk({7'h00, window_type_select}, 8'h00);
      @(posedge clk_sys) wdog_period_hw_val <= 3'h2;
      wdog_period_hw_we <= 1'b1;
      @(posedge clk_sys) wdog_period_hw_we <= 1'b0;
      tick(3);
      chk({5'h00, wdog_period_field}, 8'h02);
      rd(WATCHDOG_CONTROL_ADDR, 8'h52);
      wr(WAKE_CTRL_ADDR, 8'h04);
      chk({7'h00, wdog_stop_disable}, 8'h01);
      @(posedge clk_sys) stop_to_normal <= 1'b1;
      @(posedge clk_sys) stop_to_normal <= 1'b0;
      tick(3);
      chk({7'h00, wdog_stop_disable}, 8'h00);
      rd(WAKE_CTRL_ADDR, 8'h00);
      $display("wd bits done");
   endtask : t_wdog_bits

   task t_tolerance;
      wr(HW_CTRL_ADDR, 8'h01);
      mark = esc_n;
      fail_pulse();
      chk(8'(esc_n - mark), 8'h01);
      wr(HW_CTRL_ADDR, 8'h00);
      mark = esc_n;
      fail_pulse();
      chk(8'(esc_n - mark), 8'h00);
      fail_pulse();
      chk(8'(esc_n - mark), 8'h01);
      $display("tolerance done");
   endtask : t_tolerance

   task t_soft_reset;
      wr(HW_CTRL_ADDR, 8'h25);
      wr(WATCHDOG_CONTROL_ADDR, 8'h77);
      mark = low_n;
      wr(MODE_SUPPLY_ADDR, 8'hC0);
      tick(4);
      chk(8'(low_n - mark), 8'(RP));
      rd(HW_CTRL_ADDR, 8'h00);
      rd(WATCHDOG_CONTROL_ADDR, 8'h14);
      @(posedge clk_sys) cfg_lock_0 <= 1'b1;
      wr(HW_CTRL_ADDR, 8'h44);
      mark = low_n;
      wr(MODE_SUPPLY_ADDR, 8'hC0);
      chk(8'(low_n - mark), 8'h00);
      rd(HW_CTRL_ADDR, 8'h04);
      @(posedge clk_sys) cfg_lock_0 <= 1'b0;
      cfg_lock_1 <= 1'b1;
      wr(HW_CTRL_ADDR, 8'h44);
      wr(MODE_SUPPLY_ADDR, 8'hC0);
      rd(HW_CTRL_ADDR, 8'h40);
      @(posedge clk_sys) cfg_lock_1 <= 1'b0;
      $display("soft reset done");
   endtask : t_soft_reset

   task t_restart;
      wr(HW_CTRL_ADDR, 8'h65);
      wr(WATCHDOG_CONTROL_ADDR, 8'h77);
      @(posedge clk_sys) restart_enter <= 1'b1;
      @(posedge clk_sys) restart_enter <= 1'b0;
      tick(3);
      chk({7'h00, failure_output}, 8'h00);
      rd(HW_CTRL_ADDR, 8'h45);
      rd(WATCHDOG_CONTROL_ADDR, 8'h34);
      $display("restart done");
   endtask : t_restart

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      tick(10);
      reset <= 1'b0;
      tick(6);
      t_reset_values();
      t_hw_bits();
      t_wdog_bits();
      t_tolerance();
      t_soft_reset();
      t_restart();
      end_sim();
   end

   // A hang is cut short well inside the cycle budget.
   initial begin
      #3000000;
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
   end
endmodule : hwc_ctrl_regs_tb_top

bind hwc_ctrl_regs hwc_ctrl_regs_asserts #(.RST_PULSE_CYC(RST_PULSE_CYC)) chk_u (.clk_sys,
   .reset, .spi_sel_n_pin, .restart_enter, .stop_to_normal, .failure_triggered,
   .fo_pin_configured, .wdog_trigger_fail, .wdog_period_hw_we, .wdog_period_hw_val,
   .reset_out_n, .soft_reset_evt, .failure_output, .charge_pump_enable, .wdog_escalate,
   .wdog_stop_disable, .wdog_period_field, .wd_parity_reject);
